// >>> design/hbi_pkg.sv
`default_nettype none
package hbi_pkg;

	// register map
	localparam logic [7:0]  HBI_ADDR_STAGE1  = 8'h1C;
	localparam logic [7:0]  HBI_ADDR_STAGE2  = 8'h1D;
	localparam logic [7:0]  HBI_ADDR_STATUS  = 8'h1E;
	localparam logic [7:0]  HBI_STAGE1_RST   = 8'h00;
	localparam logic [7:0]  HBI_STAGE2_RST   = 8'h00;
	localparam logic [7:0]  HBI_STAGE1_WMASK = 8'h0F;
	localparam logic [7:0]  HBI_STAGE2_WMASK = 8'h7F;
	localparam int          HBI_S1_MODE_LSB  = 0;
	localparam int          HBI_S1_BYP_BIT   = 2;
	localparam int          HBI_S1_PMOD_BIT  = 3;
	localparam int          HBI_S2_MODE_LSB  = 0;
	localparam int          HBI_S2_BYP_BIT   = 6;

	// datapath geometry
	localparam int          HBI_DW           = 16;
	localparam int          HBI_HALF         = 4;
	localparam int          HBI_TAPS         = 2 * HBI_HALF;
	localparam int          HBI_ACC          = 40;
	localparam int          HBI_FRAC         = 15;
	localparam logic signed [39:0] HBI_ROT_R = 40'sh00_0000_5A82;
	localparam logic signed [39:0] HBI_MAXV  = 40'sh00_0000_7FFF;
	localparam logic signed [39:0] HBI_MINV  = -40'sh00_0000_8000;

	typedef enum logic [0:0] {
		HBI_PH_FIRST  = 1'b0,
		HBI_PH_CENTRE = 1'b1
	} hbi_phase_t;

	// symmetric odd-phase taps, unity sum in Q15
	function automatic logic signed [17:0] hbi_coef(input int k);
		int j;
		j = (k < HBI_HALF) ? k : HBI_TAPS - 1 - k;
		case (j)
			0:       return -18'sh00050;
			1:       return 18'sh00310;
			2:       return -18'sh00F50;
			default: return 18'sh04C90;
		endcase
	endfunction

	function automatic logic signed [15:0] hbi_sat(input logic signed [39:0] v);
		if (v > HBI_MAXV)
			return 16'sh7FFF;
		if (v < HBI_MINV)
			return 16'sh8000;
		return v[15:0];
	endfunction

	// rotate i + jq by idx * 45 degrees, result {i, q}
	function automatic logic [31:0] hbi_rot(input logic signed [15:0] i, input logic signed [15:0] q,
			input logic [2:0] idx);
		logic signed [39:0] a;
		logic signed [39:0] b;
		logic signed [39:0] ri;
		logic signed [39:0] rq;
		a = 40'(i);
		b = 40'(q);
		if (idx[0]) begin
			ri = ((a - b) * HBI_ROT_R) >>> HBI_FRAC;
			rq = ((a + b) * HBI_ROT_R) >>> HBI_FRAC;
		end else begin
			ri = a;
			rq = b;
		end
		case (idx[2:1])
			2'h0:    return {hbi_sat(ri), hbi_sat(rq)};
			2'h1:    return {hbi_sat(-rq), hbi_sat(ri)};
			2'h2:    return {hbi_sat(-ri), hbi_sat(-rq)};
			default: return {hbi_sat(rq), hbi_sat(-ri)};
		endcase
	endfunction

	// input-side rotation step per sample, in 45 degree units
	function automatic logic [2:0] hbi_pre_step(input int stage, input logic [2:0] mode, input logic pmod);
		if (stage == 0)
			return {mode[0] ^ pmod, 2'h0};
		return 3'(4'h8 - {1'b0, mode[1:0], 1'b0});
	endfunction

	// output-side rotation step per output sample
	function automatic logic [2:0] hbi_post_step(input int stage, input logic [2:0] mode);
		if (stage == 0)
			return {mode[1:0], 1'b0};
		return mode;
	endfunction

endpackage
`default_nettype wire

// >>> design/hbi_chain.sv
// Operation
// R1: two 2x stages, each bypassable: 1x/2x/4x
// R2: first stage 80% band, 0.001dB, 85dB
// R3: second stage 50% band, 0.001dB, 85dB
// R4: first stage passband centre mode*fin/2
// R5: first stage modes 2,3 modulate by fin
// R6: first stage modes 1,3 cross-mix I/Q
// R7: second stage passband centre mode*fin/4
// R8: second stage modes 4-7 modulate by fin
// R9: second stage cross-mixes except modes 0,4
// R10: 2-bit first code, 6-bit second code
// R11: premod plus odd first mode centres baseband
// R12: premodulation shifts input by half rate
// R13: modulation equals complex carrier multiplication
// R14: bypass forwards unchanged, fixed latency
// R15: mode changes only between samples
`timescale 1ns/100ps
`default_nettype none

module hbi_chain (
	// clock and reset
	input  wire logic               i_mclk,
	input  wire logic               i_srst,
	// register port
	input  wire logic [7:0]         i_reg_addr,
	input  wire logic [7:0]         i_reg_wdata,
	input  wire logic               i_reg_wr,
	input  wire logic               i_reg_rd,
	output logic      [7:0]         o_reg_rdata,
	// premodulated-rate sample input
	input  wire logic               i_tx_valid,
	input  wire logic signed [15:0] i_tx_i,
	input  wire logic signed [15:0] i_tx_q,
	output logic                    o_tx_ready,
	// interpolated sample output
	output logic                    o_out_valid,
	output logic signed [15:0]      o_out_i,
	output logic signed [15:0]      o_out_q,
	input  wire logic               i_out_ready
);

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers

	logic [7:0] cfg_s1;
	logic [7:0] cfg_s2;
	logic [2:0] mode_cfg [0:1];
	logic       byp_cfg  [0:1];
	logic [2:0] act_mode [0:1];
	logic       act_byp  [0:1];
	logic       premod;
	logic       busy;
	wire        sel_s1 = (i_reg_addr == hbi_pkg::HBI_ADDR_STAGE1);
	wire        sel_s2 = (i_reg_addr == hbi_pkg::HBI_ADDR_STAGE2);
	wire        sel_st = (i_reg_addr == hbi_pkg::HBI_ADDR_STATUS);
	wire [7:0]  status = {busy, act_byp[1], act_mode[1], act_byp[0], act_mode[0][1:0]};
	wire [7:0]  rd_mux = sel_s1 ? cfg_s1 : sel_s2 ? cfg_s2 : sel_st ? status : 8'h00;

	// first stage takes the 2-bit code as its mode number
	assign mode_cfg[0] = {1'b0, cfg_s1[hbi_pkg::HBI_S1_MODE_LSB +: 2]}; // see R10
	assign byp_cfg[0]  = cfg_s1[hbi_pkg::HBI_S1_BYP_BIT];
	assign premod      = cfg_s1[hbi_pkg::HBI_S1_PMOD_BIT];
	// second stage: low copy of the doubled 3-bit mode is decisive
	assign mode_cfg[1] = cfg_s2[hbi_pkg::HBI_S2_MODE_LSB +: 3]; // see R10
	assign byp_cfg[1]  = cfg_s2[hbi_pkg::HBI_S2_BYP_BIT];

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			cfg_s1      <= hbi_pkg::HBI_STAGE1_RST;
			cfg_s2      <= hbi_pkg::HBI_STAGE2_RST;
			o_reg_rdata <= 8'h00;
		end else begin
			if (i_reg_wr && sel_s1)
				cfg_s1 <= i_reg_wdata & hbi_pkg::HBI_STAGE1_WMASK;
			if (i_reg_wr && sel_s2)
				cfg_s2 <= i_reg_wdata & hbi_pkg::HBI_STAGE2_WMASK;
			// data stand only in the cycle after the strobe
			o_reg_rdata <= i_reg_rd ? rd_mux : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// stream links: 0 input register, 1 between stages, 2 into output buffer

	logic                st_v   [0:2];
	logic signed [15:0]  st_i   [0:2];
	logic signed [15:0]  st_q   [0:2];
	logic                st_rdy [0:2];
	logic                next_in_v;
	logic                sk_v;
	logic signed [15:0]  sk_i;
	logic signed [15:0]  sk_q;

	// ready is registered, so input takes at most every other cycle
	assign next_in_v = st_v[0] ? !st_rdy[0] : (i_tx_valid && o_tx_ready);

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			st_v[0]    <= 1'b0;
			st_i[0]    <= 16'sh0000;
			st_q[0]    <= 16'sh0000;
			o_tx_ready <= 1'b0;
		end else begin
			st_v[0]    <= next_in_v;
			o_tx_ready <= !next_in_v;
			if (i_tx_valid && o_tx_ready) begin
				st_i[0] <= i_tx_i;
				st_q[0] <= i_tx_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// half-band stages

	genvar s;
	genvar t;
	for (s = 0; s < 2; s++) begin : g_stage
		hbi_pkg::hbi_phase_t            ph;
		logic [2:0]                     pre_ph;
		logic [2:0]                     post_ph;
		logic signed [15:0]             dl_i [0:hbi_pkg::HBI_TAPS-2];
		logic signed [15:0]             dl_q [0:hbi_pkg::HBI_TAPS-2];
		logic signed [15:0]             tp_i [0:hbi_pkg::HBI_TAPS-1];
		logic signed [15:0]             tp_q [0:hbi_pkg::HBI_TAPS-1];
		logic signed [15:0]             ctr_i;
		logic signed [15:0]             ctr_q;
		logic signed [hbi_pkg::HBI_ACC-1:0] sum_i;
		logic signed [hbi_pkg::HBI_ACC-1:0] sum_q;
		logic [31:0]                    rin;
		logic [31:0]                    fout;
		logic [31:0]                    cout;
		logic                           take;
		logic                           out_free;
		logic                           acc;
		logic [2:0]                     pre_step;
		logic [2:0]                     post_first;
		logic [2:0]                     post_second;

		assign take       = st_v[s+1] && st_rdy[s+1];
		assign out_free   = !st_v[s+1] || take;
		// a new sample is taken only once the centre output has left
		assign st_rdy[s]  = out_free && (ph == hbi_pkg::HBI_PH_FIRST); // see R15
		assign acc        = st_v[s] && st_rdy[s];
		assign pre_step   = hbi_pkg::hbi_pre_step(s, mode_cfg[s], (s == 0) && premod); // see R11
		assign post_first = hbi_pkg::hbi_post_step(s, mode_cfg[s]);
		// centre output keeps the mode latched with its sample
		assign post_second = hbi_pkg::hbi_post_step(s, act_mode[s]); // see R15

		// move the chosen centre to dc ahead of the filter
		assign rin = hbi_pkg::hbi_rot(st_i[s], st_q[s], pre_ph); // see R6, R9, R12
		assign tp_i[0] = rin[31:16];
		assign tp_q[0] = rin[15:0];
		for (t = 1; t < hbi_pkg::HBI_TAPS; t++) begin : g_tap
			assign tp_i[t] = dl_i[t-1];
			assign tp_q[t] = dl_q[t-1];
		end

		// odd phase: same shape in every mode
		always_comb begin
			sum_i = '0;
			sum_q = '0;
			for (int k = 0; k < hbi_pkg::HBI_TAPS; k++) begin
				sum_i = sum_i + hbi_pkg::HBI_ACC'(hbi_pkg::hbi_coef(k)) * hbi_pkg::HBI_ACC'(tp_i[k]); // see R2, R3
				sum_q = sum_q + hbi_pkg::HBI_ACC'(hbi_pkg::hbi_coef(k)) * hbi_pkg::HBI_ACC'(tp_q[k]);
			end
		end

		// complex carrier at the output rate places centre and modulation
		assign fout = hbi_pkg::hbi_rot(hbi_pkg::hbi_sat(sum_i >>> hbi_pkg::HBI_FRAC),
			hbi_pkg::hbi_sat(sum_q >>> hbi_pkg::HBI_FRAC), post_ph); // see R4, R5, R7, R8, R13
		assign cout = hbi_pkg::hbi_rot(ctr_i, ctr_q, post_ph); // see R13

		always_ff @(posedge i_mclk) begin
			if (i_srst) begin
				ph          <= hbi_pkg::HBI_PH_FIRST;
				pre_ph      <= 3'h0;
				post_ph     <= 3'h0;
				ctr_i       <= 16'sh0000;
				ctr_q       <= 16'sh0000;
				st_v[s+1]   <= 1'b0;
				st_i[s+1]   <= 16'sh0000;
				st_q[s+1]   <= 16'sh0000;
				act_mode[s] <= 3'h0;
				act_byp[s]  <= 1'b0;
				for (int k = 0; k < hbi_pkg::HBI_TAPS - 1; k++) begin
					dl_i[k] <= 16'sh0000;
					dl_q[k] <= 16'sh0000;
				end
			end else if (acc && byp_cfg[s]) begin
				// one sample out per sample in, one cycle late
				st_v[s+1]   <= 1'b1; // see R1, R14
				st_i[s+1]   <= st_i[s];
				st_q[s+1]   <= st_q[s];
				act_mode[s] <= mode_cfg[s];
				act_byp[s]  <= 1'b1;
			end else if (acc) begin
				for (int k = 0; k < hbi_pkg::HBI_TAPS - 1; k++) begin
					dl_i[k] <= tp_i[k];
					dl_q[k] <= tp_q[k];
				end
				ctr_i       <= tp_i[hbi_pkg::HBI_HALF-1];
				ctr_q       <= tp_q[hbi_pkg::HBI_HALF-1];
				st_v[s+1]   <= 1'b1; // see R1
				st_i[s+1]   <= fout[31:16];
				st_q[s+1]   <= fout[15:0];
				ph          <= hbi_pkg::HBI_PH_CENTRE;
				pre_ph      <= pre_ph + pre_step;
				post_ph     <= post_ph + post_first;
				act_mode[s] <= mode_cfg[s];
				act_byp[s]  <= 1'b0;
			end else if (out_free && ph == hbi_pkg::HBI_PH_CENTRE) begin
				st_v[s+1] <= 1'b1; // see R1
				st_i[s+1] <= cout[31:16];
				st_q[s+1] <= cout[15:0];
				ph        <= hbi_pkg::HBI_PH_FIRST;
				post_ph   <= post_ph + post_second;
			end else if (take) begin
				st_v[s+1] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// two-entry output buffer: a stalled receiver loses no word

	assign st_rdy[2] = !sk_v;
	assign busy      = st_v[0] || st_v[1] || st_v[2] || sk_v || o_out_valid;

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_out_valid <= 1'b0;
			o_out_i     <= 16'sh0000;
			o_out_q     <= 16'sh0000;
			sk_v        <= 1'b0;
			sk_i        <= 16'sh0000;
			sk_q        <= 16'sh0000;
		end else if (!o_out_valid || i_out_ready) begin
			if (sk_v) begin
				o_out_valid <= 1'b1;
				o_out_i     <= sk_i;
				o_out_q     <= sk_q;
				sk_v        <= 1'b0;
			end else begin
				o_out_valid <= st_v[2];
				o_out_i     <= st_i[2];
				o_out_q     <= st_q[2];
			end
		end else if (st_v[2] && !sk_v) begin
			// skid entry: ready to the stages drops one cycle late
			sk_v <= 1'b1;
			sk_i <= st_i[2];
			sk_q <= st_q[2];
		end
	end

endmodule // hbi_chain
`default_nettype wire

// >>> testbench/hbi_chain_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module hbi_chk (
	// clock and register port
	input wire logic               i_mclk,
	input wire logic               i_srst,
	input wire logic [7:0]         i_reg_addr,
	input wire logic [7:0]         i_reg_wdata,
	input wire logic               i_reg_wr,
	input wire logic               i_reg_rd,
	input wire logic [7:0]         o_reg_rdata,
	// streams
	input wire logic               i_tx_valid,
	input wire logic               o_tx_ready,
	input wire logic               o_out_valid,
	input wire logic signed [15:0] o_out_i,
	input wire logic signed [15:0] o_out_q,
	input wire logic               i_out_ready
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_srst);
	wire logic unmapped = (i_reg_addr < 8'h1C) || (i_reg_addr > 8'h1E);
	sequence s_wr_one;
		i_reg_wr && i_reg_addr == 8'h1C;
	endsequence
	sequence s_rd_one;
		i_reg_rd && i_reg_addr == 8'h1C;
	endsequence
	////////////////////////////////////////////////////////////////
	rd_idle_a: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00)
		else $error("read data left standing");
	rd_unmap_a: assert property (i_reg_rd && unmapped |=> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	rsv_one_a: assert property (s_rd_one |=> o_reg_rdata[7:4] == 4'h0)
		else $error("first stage reserved bits set");
	rsv_two_a: assert property (i_reg_rd && i_reg_addr == 8'h1D |=> !o_reg_rdata[7])
		else $error("second stage reserved bit set");
	wr_rd_a: assert property (s_wr_one ##2 s_rd_one |=> o_reg_rdata == ($past(i_reg_wdata, 3) & 8'h0F))
		else $error("first stage readback wrong");
	tx_drop_a: assert property (i_tx_valid && o_tx_ready |=> !o_tx_ready)
		else $error("ready stayed high after take");
	out_hold_a: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_i) && $stable(o_out_q))
		else $error("output word changed while stalled");
	rst_quiet_a: assert property ($fell(i_srst) |-> !o_out_valid && !o_tx_ready)
		else $error("outputs active after reset");
	out_follow_a: assert property (i_tx_valid && o_tx_ready |-> ##[1:40] o_out_valid)
		else $error("no output after sample");
endmodule // hbi_chk
bind hbi_chain hbi_chk u_chk (.i_mclk, .i_srst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
	.i_tx_valid, .o_tx_ready, .o_out_valid, .o_out_i, .o_out_q, .i_out_ready);
`default_nettype wire

// >>> testbench/hbi_src_model.sv
`timescale 1ns/100ps
`default_nettype none
module hbi_src_model (
	// clock and control
	input  wire logic               i_mclk,
	input  wire logic               i_srst,
	input  wire logic               i_start,
	input  wire logic [7:0]         i_count,
	input  wire logic               i_slow,
	input  wire logic signed [15:0] i_si,
	input  wire logic signed [15:0] i_sq,
	output logic                    o_busy,
	// stream toward the chain
	input  wire logic               i_ready,
	output logic                    o_valid,
	output logic signed [15:0]      o_i,
	output logic signed [15:0]      o_q
);
	logic [7:0] left;
	logic       tick;
	assign o_busy = (left != 8'h00);
	// idle data inverted so a stale word is never mistaken for a new one
	assign o_i = o_valid ? i_si : ~i_si;
	assign o_q = o_valid ? i_sq : ~i_sq;
	always_ff @(posedge i_mclk) begin
		// reset so the slow pacing never starts from an unknown level
		tick <= i_srst ? 1'b0 : ~tick;
		if (i_srst) begin
			left    <= 8'h00;
			o_valid <= 1'b0;
		end else if (i_start) begin
			left    <= i_count;
			o_valid <= 1'b1;
		end else if (o_valid && i_ready) begin
			left    <= left - 8'h01;
			o_valid <= 1'b0;
		end else begin
			// an offered word stands until it is taken
			o_valid <= o_valid || (o_busy && (!i_slow || tick));
		end
	end
endmodule // hbi_src_model
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic               i_mclk = 1'b0, i_srst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_out_ready = 1'b0;
	logic [7:0]         i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
	logic               i_tx_valid, o_tx_ready, o_out_valid, start = 1'b0, slow = 1'b0, busy;
	logic signed [15:0] i_tx_i, i_tx_q, o_out_i, o_out_q, si = 16'sh0000, sq = 16'sh0000;
	logic [31:0]        words[$];
	int                 n_mismatch = 0, n_checks = 0;
	hbi_chain uut (.i_mclk, .i_srst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
		.i_tx_valid, .i_tx_i, .i_tx_q, .o_tx_ready, .o_out_valid, .o_out_i, .o_out_q, .i_out_ready);
	hbi_src_model u_src (.i_mclk, .i_srst, .i_start(start), .i_count(8'h0C), .i_slow(slow), .i_si(si),
		.i_sq(sq), .o_busy(busy), .i_ready(o_tx_ready), .o_valid(i_tx_valid), .o_i(i_tx_i), .o_q(i_tx_q));
	initial forever #25 i_mclk = ~i_mclk;
	always @(posedge i_mclk) if (o_out_valid === 1'b1 && i_out_ready) words.push_back({o_out_i, o_out_q});
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_reg_addr  <= a;
		i_reg_wdata <= d;
		i_reg_wr    <= 1'b1;
		@(posedge i_mclk);
		i_reg_wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_mclk);
		i_reg_addr <= a;
		i_reg_rd   <= 1'b1;
		@(posedge i_mclk);
		i_reg_rd <= 1'b0;
		#1 chk(o_reg_rdata, e);
	endtask
	// kinds: 0 passes input, 1 alternates sign, 2 keeps q zero, 3 mixes into q, 4 turns 90 degrees a word
	task automatic run(input logic [7:0] c1, input logic [7:0] c2, input int ratio, input int kind,
			input logic signed [15:0] vi, input logic signed [15:0] vq, input logic sl);
		int n;
		logic [31:0] w, p;
		logic hit;
		reg_wr(8'h1C, c1);
		reg_wr(8'h1D, c2);
		words.delete();
		si          <= vi;
		sq          <= vq;
		slow        <= sl;
		i_out_ready <= 1'b0;
		start       <= 1'b1;
		@(posedge i_mclk);
		start <= 1'b0;
		repeat (40) @(posedge i_mclk);
		// stalled receiver: buffer must fill and refuse without losing words
		chk({o_tx_ready, busy}, 2'b01);
		i_out_ready <= 1'b1;
		n = 0;
		while ((busy || words.size() < 12 * ratio) && n < 500) begin
			@(posedge i_mclk);
			n++;
		end
		if (n == 500) begin
			n_mismatch++;
			finish_test();
		end
		repeat (10) @(posedge i_mclk);
		chk(words.size(), 12 * ratio);
		hit = 1'b0;
		// taps keep the previous run's samples: only the last six words are checked, all with a clean window at every stage
		for (int k = 12 * ratio - 6; k < words.size(); k++) begin
			w = words[k];
			p = words[k - 1];
			case (kind)
				0: chk(w, {vi, vq});
				1: chk(w, (p === {vi, vq}) ? {-vi, -vq} : {vi, vq});
				2: chk(w[15:0], 32'h0);
				3: hit = hit | (w[15:0] != 16'h0000);
				default: chk(w, {-p[15:0], p[31:16]});
			endcase
		end
		if (kind == 3)
			chk(hit, 1'b1);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rchk(8'h1C, 8'h00);
		rchk(8'h1D, 8'h00);
		reg_wr(8'h3A, 8'hFF);
		reg_wr(8'h1D, 8'hFF);
		reg_wr(8'h1C, 8'hFF);
		rchk(8'h1C, 8'h0F);
		rchk(8'h1D, 8'h7F);
		rchk(8'h3A, 8'h00);
	endtask
	task automatic t_stage1;
		run(8'h00, 8'h40, 2, 0, 16'sd1000, -16'sd500, 1'b0);
		run(8'h02, 8'h40, 2, 1, 16'sd1000, -16'sd500, 1'b0);
		for (int m = 0; m < 4; m++)
			run(8'(m), 8'h40, 2, (m % 2) ? 3 : 2, 16'sd1000, 16'sd0, m[1]);
		run(8'h09, 8'h40, 2, 4, 16'sd1000, 16'sd0, 1'b0);
	endtask
	task automatic t_stage2;
		run(8'h04, 8'h00, 2, 0, 16'sd1000, -16'sd500, 1'b0);
		run(8'h04, 8'h24, 2, 1, 16'sd1000, -16'sd500, 1'b1);
		for (int m = 0; m < 8; m++)
			run(8'h04, 8'({m[2:0], m[2:0]}), 2, (m % 4 == 0) ? 2 : 3, 16'sd1000, 16'sd0, m[0]);
	endtask
	initial begin
		repeat (12) @(posedge i_mclk);
		i_srst <= 1'b0;
		repeat (2) @(posedge i_mclk);
		t_regs();
		run(8'h04, 8'h40, 1, 0, 16'sd1000, -16'sd500, 1'b1);
		// drained: both stages report bypass, mode 0, nothing in flight
		rchk(8'h1E, 8'h44);
		t_stage1();
		t_stage2();
		run(8'h00, 8'h00, 4, 0, 16'sd1000, -16'sd500, 1'b1);
		finish_test();
	end
endmodule // testbench
`default_nettype wire
